/* File: dv/sec_ctrl_chk.sv */
// bus and serial framing assertions for the eeprom command engine
`timescale 1ns/100ps

module sec_ctrl_chk import sec_pkg::*; #(
   parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire sec_pins_s   serial_memory_pins
);
   sec_pins_s   p;
   logic        clk_q_r;
   logic [4:0]  nclk_r;
   logic [19:0] nsel_r;
   assign p = serial_memory_pins;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // ==================== helpers ====================
   always_ff @(posedge aclk) begin
      clk_q_r <= p.clk;
      nclk_r  <= p.sel ? nclk_r + 5'(p.clk && !clk_q_r) : 5'h00;
      nsel_r  <= p.sel ? nsel_r + 20'h1 : 20'h0;
   end

   // ==================== assertions ====================
   a_frame_clocks : assert property ($fell(p.sel) |-> nclk_r inside {5'h00, 5'h0a, 5'h12})
      else $error("frame clock count wrong");
   a_clk_high : assert property ($rose(p.clk) && p.sel |-> p.clk [*4] ##1 !p.clk)
      else $error("serial clock high time wrong");
   a_start_bit : assert property ($rose(p.clk) && p.sel && nclk_r == 5'h00 |-> p.dat_o && p.dat_oe)
      else $error("frame start bit missing");
   a_addr_driven : assert property (p.sel && nclk_r inside {[1:9]} |-> p.dat_oe)
      else $error("opcode or address not driven");
   a_poll_bound : assert property (nsel_r <= 20'(TIMEOUT_CYCLES + 16))
      else $error("select held past timeout");
   a_b_hold : assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_b_after : assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write response late");
   a_b_blocks : assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("ready during response");
   a_r_latency : assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   a_r_hold : assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   c_long : cover property ($fell(p.sel) && nclk_r == 5'h12);
   c_short : cover property ($fell(p.sel) && nclk_r == 5'h0a);
   c_slverr : cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule

bind sec_ctrl sec_ctrl_chk #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_sec_ctrl_chk (.aclk, .aresetn, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .serial_memory_pins);

/* File: dv/sec_ctrl_tb.sv */
// self-checking bench for the eeprom command engine
`timescale 1ns/100ps

module sec_ctrl_tb import sec_pkg::*; ;
   logic        aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
   logic [7:0]  awa = 8'h00, ara = 8'h00, seed = 8'h53, d1, d2;
   logic [31:0] wd = 32'h0, v;
   logic [1:0]  mii = 2'h0, qb[$];
   logic [19:0] wc = 20'h1e;
   logic [47:0] st;
   logic [65:0] ent, qr[$];
   logic [6:0]  a;
   wire         awr, wrr, bv, arr, rv, din, mdo;
   wire  [1:0]  br, rr;
   wire  [31:0] rdat;
   wire  [47:0] sta;
   wire sec_pins_s pins;
   int          num_errors = 0, n_checks = 0, i;

   sec_ctrl #(.TIMEOUT_CYCLES(200)) u_sec_ctrl (.aclk, .aresetn, .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrr),
      .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
      .serial_memory_pins(pins), .serial_memory_data_pin_i(din), .mii_monitor(mii), .station_address(sta));
   sec_eeprom_model u_sec_eeprom_model (.aclk, .pins, .wait_cyc(wc), .dout(mdo));
   assign din = pins.dat_oe ? pins.dat_o : mdo;

   // ==================== tasks ====================
   function automatic logic [7:0] lfsr();
      seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
      return seed;
   endfunction
   task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
      n_checks++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic hang();
      chk("wait", 34'h1, 34'h0);
      end_of_test();
   endtask
   task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] r);
      int k;
      qb.push_back(r);
      @(posedge aclk);
      awa <= ad;
      wd  <= d;
      awv <= 1'b1;
      wv  <= 1'b1;
      bry <= lfsr() > 8'h80;
      for (k = 0; k < 50; k++) begin
         @(posedge aclk);
         if (awr) awv <= 1'b0;
         if (wrr) wv <= 1'b0;
         if (bv && bry) break;
         bry <= 1'b1;
      end
      bry <= 1'b0;
      if (k == 50) hang();
   endtask
   task automatic rd(input logic [7:0] ad, input logic [33:0] e, input logic [31:0] m, output logic [31:0] o);
      int k;
      qr.push_back({m, e});
      @(posedge aclk);
      ara <= ad;
      arv <= 1'b1;
      rry <= lfsr() > 8'h80;
      for (k = 0; k < 50; k++) begin
         @(posedge aclk);
         if (arr) arv <= 1'b0;
         if (rv && rry) break;
         rry <= 1'b1;
      end
      o = rdat;
      rry <= 1'b0;
      if (k == 50) hang();
   endtask
   task automatic poll();
      int k;
      v = 32'h8000_0000;
      for (k = 0; k < 400 && v[31]; k++) rd(OFS_CMD, 34'h0, 32'h0, v);
      if (k == 400) hang();
   endtask
   task automatic cmd(input logic [2:0] op, input logic [6:0] ad);
      wr(OFS_CMD, {1'b1, op, 21'h0, ad}, RESP_OKAY);
      poll();
   endtask
   task automatic rdb(input logic [6:0] ad, input logic [7:0] e);
      cmd(OP_READ, ad);
      rd(OFS_DATA, {RESP_OKAY, 24'h0, e}, 32'hff, v);
   endtask

   // ==================== result watcher ====================
   always @(posedge aclk) begin
      if (rv && rry) begin
         ent = qr.pop_front();
         if (ent[65:34] != 32'h0) chk("rdata", ent[33:0], {rr, rdat & ent[65:34]});
      end
      if (bv && bry) chk("bresp", {32'h0, qb.pop_front()}, {32'h0, br});
   end

   // ==================== stimulus ====================
   initial forever #25 aclk = ~aclk;
   initial begin
      u_sec_eeprom_model.mem = '{default: 8'h00};
      u_sec_eeprom_model.mem[0] = SIGNATURE;
      for (i = 1; i < 7; i++) begin
         u_sec_eeprom_model.mem[i] = lfsr();
         st[(i - 1) * 8 +: 8] = u_sec_eeprom_model.mem[i];
      end
      a  = 7'(lfsr()) | 7'h08;
      d1 = lfsr();
      d2 = ~d1;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rd(OFS_CMD, {RESP_OKAY, CMD_RST}, 32'hf000_0000, v);
      poll();
      rd(OFS_CMD, {RESP_OKAY, 32'h100}, 32'h300, v);
      rd(OFS_ADDR_LO, {RESP_OKAY, st[31:0]}, 32'hffff_ffff, v);
      rd(OFS_ADDR_HI, {RESP_OKAY, 16'h0, st[47:32]}, 32'hffff, v);
      wr(OFS_DATA, {24'h0, d1}, RESP_OKAY);
      cmd(OP_WRITE, a);
      rdb(a, 8'h00);
      cmd(OP_UNLK, 7'h00);
      wr(OFS_DATA, {24'h0, d1}, RESP_OKAY);
      cmd(OP_WRITE, a);
      rdb(a, d1);
      cmd(OP_LOCK, 7'h00);
      wr(OFS_DATA, {24'h0, d2}, RESP_OKAY);
      cmd(OP_WRITE, a);
      rdb(a, d1);
      cmd(OP_UNLK, 7'h00);
      cmd(OP_ERASE, a);
      rdb(a, 8'hff);
      wr(OFS_DATA, {24'h0, d2}, RESP_OKAY);
      cmd(OP_WALL, 7'h00);
      rdb(7'h7f, d2);
      cmd(OP_EALL, 7'h00);
      rdb(7'h00, 8'hff);
      wc = 20'h3e8;
      cmd(OP_ERASE, a);
      rd(OFS_CMD, {RESP_OKAY, 32'h200}, 32'h8000_0200, v);
      wc = 20'h1e;
      rdb(a, 8'hff);
      rd(OFS_CMD, {RESP_OKAY, 32'h0}, 32'h200, v);
      cmd(OP_RELOAD, 7'h00);
      rd(OFS_CMD, {RESP_OKAY, 32'h0}, 32'h100, v);
      chk("station", {2'h0, st[31:0]}, {2'h0, sta[31:0]});
      chk("station_hi", {18'h0, st[47:32]}, {18'h0, sta[47:32]});
      wr(8'h20, 32'h1, RESP_SLVERR);
      rd(8'h20, {RESP_SLVERR, 32'h0}, 32'hffff_ffff, v);
      wr(OFS_GPIO, 32'h1d, RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk("pins", 34'hb, {30'h0, pins});
      mii <= 2'(lfsr());
      wr(OFS_GPIO, 32'h03, RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk("monitor", {30'h0, mii[0], 1'b0, mii[1], 1'b1}, {30'h0, pins});
      end_of_test();
   end
endmodule

/* File: dv/sec_eeprom_model.sv */
// behavioural three-wire serial memory, 128 bytes, powers up locked
`timescale 1ns/100ps

module sec_eeprom_model import sec_pkg::*; (
   input  wire logic        aclk,
   input  wire sec_pins_s   pins,
   input  wire logic [19:0] wait_cyc,
   output      logic        dout
);
   logic [7:0]  mem [128];
   logic [17:0] sh;
   logic [7:0]  rs;
   logic [6:0]  a;
   logic [1:0]  op;
   logic        en = 1'b0, rd = 1'b0, pend = 1'b0, q = 1'b0;
   int          n = 0, bc = 0;

   // ==================== serial framing ====================
   always @(posedge pins.sel) n = 0;
   // start bit, opcode, address, data, msb first
   always @(posedge pins.clk) if (pins.sel) begin
      if (n == 0) begin
         pend = 1'b0;
         rd   = 1'b0;
      end
      sh = {sh[16:0], pins.dat_o};
      n  = n + 1;
      if (n == 10) begin
         op = sh[8:7];
         a  = sh[6:0];
         // read answers with the addressed byte
         rd = op == SOP_READ;
         rs = mem[a];
         // lock state gates every erase and write
         if (op == SOP_EXT && a == EXT_UNLK) en = 1'b1;
         if (op == SOP_EXT && a == EXT_LOCK) en = 1'b0;
         if (en && op == SOP_ERASE) mem[a] = 8'hff;
         if (en && op == SOP_EXT && a == EXT_EALL) mem = '{default: 8'hff};
         if (op == SOP_ERASE || op == SOP_EXT && a == EXT_EALL) begin
            pend = 1'b1;
            bc   = en ? int'(wait_cyc) : 0;
         end
      end
      // program one byte or all of them
      if (n == 18 && (op == SOP_WRITE || op == SOP_EXT)) begin
         if (en && op == SOP_WRITE) mem[a] = sh[7:0];
         if (en && op == SOP_EXT) mem = '{default: sh[7:0]};
         pend = 1'b1;
         bc   = en ? int'(wait_cyc) : 0;
      end
   end
   always @(negedge pins.clk) if (rd) begin
      q  = rs[7];
      rs = rs << 1;
   end
   always @(posedge aclk) if (bc > 0) bc <= bc - 1;
   // released line shows the inverse of the last bit, never a stale copy
   assign dout = pins.sel && rd ? q : pins.sel && pend ? bc == 0 : !q;
endmodule

/* File: rtl/sec_ctrl.sv */
// serial eeprom command engine with axi4-lite register access
//
// The AXI4-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/100ps

module sec_ctrl import sec_pkg::*; #(
   parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output      logic              s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output      logic              s_axi_wready,
   output      logic [1:0]        s_axi_bresp,
   output      logic              s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output      logic              s_axi_arready,
   output      logic [31:0]       s_axi_rdata,
   output      logic [1:0]        s_axi_rresp,
   output      logic              s_axi_rvalid,
   input  wire logic              s_axi_rready,
   output      sec_pins_s         serial_memory_pins,
   input  wire logic              serial_memory_data_pin_i,
   input  wire logic [1:0]        mii_monitor,
   output      logic [47:0]       station_address
);

   // ==================== state ====================
   logic              din_meta_r;
   logic              din_sync_r;
   sec_cmd_s          cmd_r;
   logic [7:0]        data_r;
   logic [47:0]       station_r;
   sec_gpio_s         gpio_r;
   sec_state_e        state_r;
   logic [PH_W-1:0]   phase_r;
   logic [4:0]        bit_r;
   logic [17:0]       tx_r;
   logic [7:0]        rx_r;
   logic [2:0]        step_r;
   logic [TO_W-1:0]   wait_r;
   logic              cs_r;
   sec_pins_s         pins_r;
   sec_pins_s         pins_nxt;
   logic              aw_have_r;
   logic [ADDR_W-1:0] aw_addr_r;
   logic              w_have_r;
   logic [31:0]       w_data_r;
   logic [3:0]        w_strb_r;
   logic              bvalid_r;
   logic [1:0]        bresp_r;
   logic              rvalid_r;
   logic [31:0]       rdata_r;
   logic [1:0]        rresp_r;

   // ==================== frame assembly ====================
   sec_op_e     op_w;
   logic        rd_w;
   logic        long_w;
   logic        prog_w;
   logic [1:0]  sop_w;
   logic [6:0]  sadr_w;
   logic [17:0] frame_w;
   logic [4:0]  last_bit_w;

   assign op_w   = sec_op_e'(cmd_r.op);
   assign rd_w   = (op_w == OP_READ) || (op_w == OP_RELOAD);
   assign long_w = rd_w || (op_w == OP_WRITE) || (op_w == OP_WALL);
   // ops that end in a ready poll
   assign prog_w = (op_w == OP_WRITE) || (op_w == OP_WALL) || (op_w == OP_ERASE) || (op_w == OP_EALL);

   assign sop_w  = rd_w                ? SOP_READ  :
                   (op_w == OP_WRITE)  ? SOP_WRITE :
                   (op_w == OP_ERASE)  ? SOP_ERASE : SOP_EXT;
   // extended ops live in the address bits
   assign sadr_w = (op_w == OP_RELOAD) ? {4'h0, step_r} :
                   (op_w == OP_UNLK)   ? EXT_UNLK :
                   (op_w == OP_LOCK)   ? EXT_LOCK :
                   (op_w == OP_EALL)   ? EXT_EALL :
                   (op_w == OP_WALL)   ? EXT_WALL : cmd_r.addr;
   // start, opcode, address, data, msb first
   assign frame_w    = {1'b1, sop_w, sadr_w, data_r};
   assign last_bit_w = long_w ? BITS_LONG - 5'd1 : BITS_SHORT - 5'd1;

   // ==================== sequencing strobes ====================
   logic ph_wrap_w;
   logic bit_end_w;
   logic frame_end_w;
   logic gap_end_w;
   logic ready_w;
   logic expire_w;
   logic sig_ok_w;
   logic reload_more_w;
   logic sclk_w;
   logic drive_w;

   assign ph_wrap_w     = (phase_r == PH_W'(SCLK_DIV - 1));
   assign bit_end_w     = (state_r == ST_SHIFT) && ph_wrap_w;
   assign frame_end_w   = bit_end_w && (bit_r == last_bit_w);
   assign gap_end_w     = (state_r == ST_GAP) && ph_wrap_w;
   // pin register and synchroniser still show the gap level for the first poll cycles
   assign ready_w       = (state_r == ST_POLL) && din_sync_r && (wait_r >= TO_W'(POLL_SETTLE));
   assign expire_w      = (state_r == ST_POLL) && (wait_r == TO_W'(TIMEOUT_CYCLES - 1));
   assign sig_ok_w      = (rx_r == SIGNATURE);
   assign reload_more_w = (op_w == OP_RELOAD) && ((step_r == 3'h0) ? sig_ok_w : (step_r != STEP_LAST));
   assign sclk_w        = (state_r == ST_SHIFT) && (phase_r >= PH_W'(SCLK_HALF));
   // the memory owns the data line during read data bits and the ready poll
   assign drive_w       = (state_r == ST_SHIFT) && !(rd_w && (bit_r >= BITS_SHORT));

   // ==================== register views and bus decode ====================
   logic [31:0] cmd_word_w;
   logic [31:0] data_word_w;
   logic [31:0] alo_word_w;
   logic [31:0] ahi_word_w;
   logic [31:0] gpio_word_w;
   logic [7:0]  ra_w;
   logic [7:0]  wa_w;
   logic        r_hit_w;
   logic        w_hit_w;
   logic [31:0] rd_word_w;
   logic [31:0] wr_old_w;
   logic [31:0] wmask_w;
   logic [31:0] wr_val_w;
   logic        wr_go_w;
   logic        host_wr_w;

   assign cmd_word_w  = cmd_r;
   assign data_word_w = {24'h00_0000, data_r};
   assign alo_word_w  = station_r[31:0];
   assign ahi_word_w  = {16'h0000, station_r[47:32]};
   assign gpio_word_w = {27'h000_0000, gpio_r};

   assign ra_w = {s_axi_araddr[7:2], 2'b00};
   assign wa_w = {aw_addr_r[7:2], 2'b00};

   assign r_hit_w = (ra_w == OFS_CMD) || (ra_w == OFS_DATA) || (ra_w == OFS_ADDR_LO) ||
                    (ra_w == OFS_ADDR_HI) || (ra_w == OFS_GPIO);
   assign w_hit_w = (wa_w == OFS_CMD) || (wa_w == OFS_DATA) || (wa_w == OFS_ADDR_LO) ||
                    (wa_w == OFS_ADDR_HI) || (wa_w == OFS_GPIO);

   assign rd_word_w = (ra_w == OFS_CMD)     ? cmd_word_w  :
                      (ra_w == OFS_DATA)    ? data_word_w :
                      (ra_w == OFS_ADDR_LO) ? alo_word_w  :
                      (ra_w == OFS_ADDR_HI) ? ahi_word_w  :
                      (ra_w == OFS_GPIO)    ? gpio_word_w : 32'h0000_0000;
   assign wr_old_w  = (wa_w == OFS_CMD)     ? cmd_word_w  :
                      (wa_w == OFS_DATA)    ? data_word_w :
                      (wa_w == OFS_ADDR_LO) ? alo_word_w  :
                      (wa_w == OFS_ADDR_HI) ? ahi_word_w  :
                      (wa_w == OFS_GPIO)    ? gpio_word_w : 32'h0000_0000;

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_lane
         assign wmask_w[8*gi +: 8] = {8{w_strb_r[gi]}};
      end
   endgenerate

   assign wr_val_w  = (wr_old_w & ~wmask_w) | (w_data_r & wmask_w);
   assign wr_go_w   = aw_have_r && w_have_r && !bvalid_r;
   // engine registers are frozen to the host while an operation runs
   assign host_wr_w = wr_go_w && !cmd_r.busy;

   // ==================== axi4-lite slave ====================
   assign s_axi_awready = !aw_have_r && !bvalid_r;
   assign s_axi_wready  = !w_have_r && !bvalid_r;
   assign s_axi_arready = !rvalid_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_have_r  <= 1'b0;
         w_data_r  <= 32'h0000_0000;
         w_strb_r  <= 4'h0;
         bvalid_r  <= 1'b0;
         bresp_r   <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (wr_go_w) begin
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            bvalid_r  <= 1'b1;
            bresp_r   <= w_hit_w ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h0000_0000;
         rresp_r  <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_r <= 1'b1;
         rdata_r  <= rd_word_w;
         rresp_r  <= r_hit_w ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   // pin configuration stays writable during an operation so a stuck memory can be released
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gpio_r <= sec_gpio_s'(GPIO_RST);
      end else if (wr_go_w && (wa_w == OFS_GPIO)) begin
         gpio_r <= sec_gpio_s'(wr_val_w[4:0]);
      end
   end

   // ==================== pin path ====================
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         din_meta_r <= 1'b0;
         din_sync_r <= 1'b0;
      end else begin
         din_meta_r <= serial_memory_data_pin_i;
         din_sync_r <= din_meta_r;
      end
   end

   // interface off: pins follow gpio values or monitor taps
   assign pins_nxt = gpio_r.if_off ?
                     sec_pins_s'{clk:    gpio_r.mon_sel ? mii_monitor[0] : gpio_r.clk_val,
                       sel:    1'b0,
                       dat_o:  gpio_r.mon_sel ? mii_monitor[1] : gpio_r.dat_val,
                       dat_oe: gpio_r.mon_sel | gpio_r.dat_oe} :
                     sec_pins_s'{clk: sclk_w, sel: cs_r, dat_o: tx_r[17], dat_oe: drive_w};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pins_r <= '0;
      end else begin
         pins_r <= pins_nxt;
      end
   end

   assign serial_memory_pins = pins_r;
   assign station_address    = station_r;

   // ==================== serial clock phase ====================
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         phase_r <= '0;
      end else if ((state_r != ST_SHIFT && state_r != ST_GAP) || ph_wrap_w) begin
         phase_r <= '0;
      end else begin
         phase_r <= phase_r + PH_W'(1);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wait_r <= '0;
      end else if (state_r == ST_POLL) begin
         wait_r <= wait_r + TO_W'(1);
      end else begin
         wait_r <= '0;
      end
   end

   // ==================== operation engine ====================
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r   <= ST_IDLE;
         // reset leaves busy set until the address fetch is over
         cmd_r     <= sec_cmd_s'(CMD_RST);
         data_r    <= 8'h00;
         station_r <= 48'h0000_0000_0000;
         step_r    <= 3'h0;
         bit_r     <= 5'd0;
         tx_r      <= 18'h0_0000;
         rx_r      <= 8'h00;
         cs_r      <= 1'b0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               // a set busy bit launches the programmed op
               if (cmd_r.busy) begin
                  tx_r    <= frame_w;
                  bit_r   <= 5'd0;
                  cs_r    <= 1'b1;
                  state_r <= ST_SHIFT;
                  if (step_r == 3'h0) begin
                     // fresh start drops a stale timeout
                     cmd_r.timeout <= 1'b0;
                     if (op_w == OP_RELOAD) begin
                        cmd_r.loaded <= 1'b0;
                     end
                  end
               end
            end
            ST_SHIFT: begin
               if (bit_end_w) begin
                  tx_r  <= {tx_r[16:0], 1'b0};
                  rx_r  <= {rx_r[6:0], din_sync_r};
                  bit_r <= bit_r + 5'd1;
               end
               // frame closes after its fixed clock count
               if (frame_end_w) begin
                  cs_r    <= 1'b0;
                  state_r <= ST_GAP;
               end
            end
            ST_GAP: begin
               if (gap_end_w) begin
                  if (prog_w) begin
                     // select high again so the memory reports ready on the data line
                     cs_r    <= 1'b1;
                     state_r <= ST_POLL;
                  end else begin
                     state_r <= ST_IDLE;
                     if (reload_more_w) begin
                        step_r <= step_r + 3'h1;
                     end else begin
                        cmd_r.busy <= 1'b0;
                        step_r     <= 3'h0;
                     end
                     // read byte lands in the same cycle that busy drops
                     if (op_w == OP_READ) begin
                        data_r <= rx_r;
                     end
                     // bytes one to six fill the station address in order
                     if (op_w == OP_RELOAD && step_r != 3'h0) begin
                        station_r[{3'(step_r - 3'h1), 3'b000} +: 8] <= rx_r;
                     end
                     // loaded only once all six bytes are in
                     if (op_w == OP_RELOAD && step_r == STEP_LAST) begin
                        cmd_r.loaded <= 1'b1;
                     end
                  end
               end
            end
            ST_POLL: begin
               if (ready_w) begin
                  cs_r       <= 1'b0;
                  cmd_r.busy <= 1'b0;
                  state_r    <= ST_IDLE;
               end else if (expire_w) begin
                  // give up, flag it and release the host
                  cs_r          <= 1'b0;
                  cmd_r.busy    <= 1'b0;
                  cmd_r.timeout <= 1'b1;
                  state_r       <= ST_IDLE;
               end
            end
            default: begin
               state_r <= ST_IDLE;
               cs_r    <= 1'b0;
            end
         endcase

         if (host_wr_w && (wa_w == OFS_CMD)) begin
            cmd_r.op   <= wr_val_w[30:28];
            cmd_r.addr <= wr_val_w[6:0];
            cmd_r.busy <= wr_val_w[31];
         end
         if (host_wr_w && (wa_w == OFS_DATA)) begin
            data_r <= wr_val_w[7:0];
         end
         if (host_wr_w && (wa_w == OFS_ADDR_LO)) begin
            station_r[31:0] <= wr_val_w;
         end
         if (host_wr_w && (wa_w == OFS_ADDR_HI)) begin
            station_r[47:32] <= wr_val_w[15:0];
         end
      end
   end

endmodule

/* File: rtl/sec_pkg.sv */
// shared constants, types and register layout of the serial eeprom command controller
package sec_pkg;

   // ==================== timing ====================
   localparam int SYS_CLK_HZ     = 20_000_000;
   localparam int TIMEOUT_MS     = 30;
   localparam int TIMEOUT_CYC    = TIMEOUT_MS * (SYS_CLK_HZ / 1000);
   localparam int SCLK_PERIOD_NS = 400;
   // serial clock period in system cycles, rounded up so the memory is never over-clocked
   localparam int SCLK_DIV       = (SCLK_PERIOD_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int SCLK_HALF      = SCLK_DIV / 2;
   localparam int PH_W           = 4;
   localparam int TO_W           = 20;
   localparam int POLL_SETTLE    = 3;

   // ==================== serial framing ====================
   localparam logic [4:0] BITS_SHORT = 5'd10;
   localparam logic [4:0] BITS_LONG  = 5'd18;
   localparam logic [1:0] SOP_READ   = 2'b10;
   localparam logic [1:0] SOP_WRITE  = 2'b01;
   localparam logic [1:0] SOP_ERASE  = 2'b11;
   localparam logic [1:0] SOP_EXT    = 2'b00;
   localparam logic [6:0] EXT_LOCK   = 7'h00;
   localparam logic [6:0] EXT_WALL   = 7'h20;
   localparam logic [6:0] EXT_EALL   = 7'h40;
   localparam logic [6:0] EXT_UNLK   = 7'h60;
   localparam logic [7:0] SIGNATURE  = 8'ha5;
   localparam logic [2:0] STEP_LAST  = 3'h6;

   // ==================== register map ====================
   localparam int         ADDR_W       = 8;
   localparam logic [7:0] OFS_CMD      = 8'h00;
   localparam logic [7:0] OFS_DATA     = 8'h04;
   localparam logic [7:0] OFS_ADDR_LO  = 8'h08;
   localparam logic [7:0] OFS_ADDR_HI  = 8'h0c;
   localparam logic [7:0] OFS_GPIO     = 8'h10;
   // busy set and reload selected: the station address fetch runs straight out of reset
   localparam logic [31:0] CMD_RST     = 32'hf000_0000;
   localparam logic [4:0]  GPIO_RST    = 5'h00;
   localparam logic [1:0]  RESP_OKAY   = 2'b00;
   localparam logic [1:0]  RESP_SLVERR = 2'b10;

   typedef enum logic [2:0] {
      OP_READ   = 3'h0,
      OP_LOCK   = 3'h1,
      OP_UNLK   = 3'h2,
      OP_WRITE  = 3'h3,
      OP_WALL   = 3'h4,
      OP_ERASE  = 3'h5,
      OP_EALL   = 3'h6,
      OP_RELOAD = 3'h7
   } sec_op_e;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_SHIFT = 4'b0010,
      ST_GAP   = 4'b0100,
      ST_POLL  = 4'b1000
   } sec_state_e;

   // eeprom_command_register layout
   typedef struct packed {
      logic        busy;
      logic [2:0]  op;
      logic [17:0] rsv_hi;
      logic        timeout;
      logic        loaded;
      logic        rsv_lo;
      logic [6:0]  addr;
   } sec_cmd_s;

   // general purpose configuration of the two serial pins
   typedef struct packed {
      logic dat_oe;
      logic dat_val;
      logic clk_val;
      logic mon_sel;
      logic if_off;
   } sec_gpio_s;

   typedef struct packed {
      logic clk;
      logic sel;
      logic dat_o;
      logic dat_oe;
   } sec_pins_s;

endpackage
